//--- design/gapm_power_manager.sv
// activity timer, management handshake and power port of the system i/o chip
//
// Summary of operation
// - idle timer expiry enters low-power management state
// - irq edges and dma requests reload timer
// - programmable i/o range access reloads timer
// - keyboard ports 60h and 64h reload timer
// - video memory and video i/o reload timer
// - disk and floppy ports reload timer
// - external event pin reloads timer
// - vector fetches reload, two vectors maskable
// - programmed wake event returns to normal
// - normal state: full speed, savings inactive
// - timer expiry asserts active-low management interrupt
// - flush cache, then remap 3xxxx while active
// - handler writes port a0h-aeh, drives clock stop
// - port gives clock control, stop, monitor off
// - resume only on enabled activity sources
`timescale 1ns/100ps
module gapm_power_manager #(
	parameter int TICK_CYC = gapm_pkg::TICK_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      arst_n,
	input  wire gapm_pkg::gapm_cfg_s       cfg,
	input  wire gapm_pkg::gapm_acc_s       acc,
	input  wire logic [15:0]               irq,
	input  wire logic [7:0]                dma_req,
	input  wire logic                      external_pm_event,
	input  wire logic                      flush_done,
	input  wire logic                      handler_exit,
	input  wire gapm_pkg::gapm_pmw_s       pm_wr,
	output logic                           mgmt_interrupt_n,
	output logic                           mgmt_active_n,
	output logic                           cache_flush,
	output logic                           remap_en,
	output logic                           remap_hit,
	output logic                           cpu_clock_stop_n,
	output logic                           cpu_clock_slow,
	output logic                           monitor_off,
	output logic                           low_power_mgmt_state
);
	function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	logic [15:0]                  irq_q;
	logic                         ext_q;
	logic [$clog2(TICK_CYC+1)-1:0] div_q;
	logic                         tick;
	logic [gapm_pkg::RELOAD_W-1:0] cnt_q;
	logic                         expired_q;
	logic                         expire_p;
	logic [gapm_pkg::SRC_N-1:0]   src;
	logic                         act;
	logic                         wake;
	logic [15:0]                  io_a;
	logic [7:0]                   vec_no;
	gapm_pkg::gapm_state_e        state_q;
	gapm_pkg::gapm_state_e        state_d;
	logic [7:0]                   pm_q [gapm_pkg::PM_DEPTH];
	logic [3:0]                   pm_idx;
	logic                         pm_sel;
	logic                         saving;

	assign io_a   = acc.addr[15:0];
	assign vec_no = acc.addr[9:2];

	// activity sources; irq and external pin count on their rising edge only
	always_comb begin
		src = '0;
		src[gapm_pkg::SRC_IRQ] = |(irq & ~irq_q);
		src[gapm_pkg::SRC_DMA] = |dma_req;
		src[gapm_pkg::SRC_EXT] = external_pm_event & ~ext_q;
		if (acc.valid && acc.is_io) begin
			src[gapm_pkg::SRC_IOR] = in_rng({8'h00, io_a}, {8'h00, cfg.io_lo}, {8'h00, cfg.io_hi});
			src[gapm_pkg::SRC_KBD] = (io_a == gapm_pkg::KBD_DATA) || (io_a == gapm_pkg::KBD_CMD);
			src[gapm_pkg::SRC_VID] = in_rng({8'h00, io_a}, {8'h00, gapm_pkg::VID_IO_LO},
				{8'h00, gapm_pkg::VID_IO_HI});
			src[gapm_pkg::SRC_DSK] = in_rng({8'h00, io_a}, {8'h00, gapm_pkg::HDD0_LO}, {8'h00, gapm_pkg::HDD0_HI})
				|| in_rng({8'h00, io_a}, {8'h00, gapm_pkg::HDD1_LO}, {8'h00, gapm_pkg::HDD1_HI})
				|| (io_a == gapm_pkg::HDD0_ALT) || (io_a == gapm_pkg::FDC_DATA);
		end
		if (acc.valid && !acc.is_io) begin
			src[gapm_pkg::SRC_VID] = in_rng(acc.addr, gapm_pkg::VID_MEM_LO, gapm_pkg::VID_MEM_HI);
			src[gapm_pkg::SRC_VEC] = (acc.addr <= gapm_pkg::VEC_HI)
				&& !(cfg.vec_mask_en[0] && vec_no == cfg.vec_mask0)
				&& !(cfg.vec_mask_en[1] && vec_no == cfg.vec_mask1);
		end
	end

	assign act  = |(src & cfg.act_en);
	// only enabled sources may end the low-power state
	assign wake = |(src & cfg.wake_en);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 16'h0000;
			ext_q <= 1'b0;
		end else begin
			irq_q <= irq;
			ext_q <= external_pm_event;
		end
	end

	// tick divider: the timer counts in coarse units to keep its width small
	assign tick = (div_q == '0);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= '0;
		end else if (tick) begin
			div_q <= ($clog2(TICK_CYC+1))'(TICK_CYC - 1);
		end else begin
			div_q <= div_q - 1'b1;
		end
	end

	// idle countdown; starts full after reset so the system is not put down at once
	assign expire_p = (cnt_q == '0) && !expired_q && !act;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q     <= '1;
			expired_q <= 1'b0;
		end else if (act) begin
			cnt_q     <= cfg.reload;
			expired_q <= 1'b0;
		end else begin
			if (tick && cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
			if (expire_p) begin
				expired_q <= 1'b1;
			end
		end
	end

	// management sequence: interrupt, flush, remap while handler runs, then low power
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			gapm_pkg::ST_NORMAL: begin
				if (expire_p) begin
					state_d = gapm_pkg::ST_FLUSH;
				end
			end
			gapm_pkg::ST_FLUSH: begin
				if (flush_done) begin
					state_d = gapm_pkg::ST_ACTIVE;
				end
			end
			gapm_pkg::ST_ACTIVE: begin
				// the cpu saves its context and runs the handler meanwhile
				if (handler_exit) begin
					state_d = gapm_pkg::ST_GREEN;
				end
			end
			gapm_pkg::ST_GREEN: begin
				if (wake) begin
					state_d = gapm_pkg::ST_NORMAL;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= gapm_pkg::ST_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// power management port a0h-aeh, written by the handler
	assign pm_sel = pm_wr.wr && pm_wr.addr >= gapm_pkg::PM_FIRST && pm_wr.addr <= gapm_pkg::PM_LAST;
	assign pm_idx = 4'(pm_wr.addr - gapm_pkg::PM_FIRST);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < gapm_pkg::PM_DEPTH; i++) begin
				pm_q[i] <= 8'h00;
			end
		end else if (pm_sel) begin
			pm_q[pm_idx] <= pm_wr.data;
		end
	end

	// port contents only take effect outside the normal state
	assign saving = (state_d != gapm_pkg::ST_NORMAL);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_clock_stop_n <= 1'b1;
			cpu_clock_slow   <= 1'b0;
			monitor_off      <= 1'b0;
		end else begin
			cpu_clock_stop_n <= !(saving && pm_q[gapm_pkg::PM_STOP_IDX][0]);
			cpu_clock_slow   <= saving && pm_q[gapm_pkg::PM_CLK_IDX][0];
			monitor_off      <= saving && pm_q[gapm_pkg::PM_MON_IDX][0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mgmt_interrupt_n     <= 1'b1;
			mgmt_active_n        <= 1'b1;
			cache_flush          <= 1'b0;
			remap_en             <= 1'b0;
			remap_hit            <= 1'b0;
			low_power_mgmt_state <= 1'b0;
		end else begin
			mgmt_interrupt_n     <= (state_d != gapm_pkg::ST_FLUSH);
			cache_flush          <= (state_d == gapm_pkg::ST_FLUSH);
			mgmt_active_n        <= (state_d != gapm_pkg::ST_ACTIVE);
			remap_en             <= (state_d == gapm_pkg::ST_ACTIVE);
			remap_hit            <= (state_d == gapm_pkg::ST_ACTIVE) && acc.valid && !acc.is_io
				&& acc.addr[19:16] == gapm_pkg::REMAP_SEG;
			low_power_mgmt_state <= saving;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	timer_reload_a: assert property (act |=> cnt_q == $past(cfg.reload)) else $error("timer not reloaded");
	expiry_once_a: assert property (expire_p |=> expired_q && !expire_p) else $error("expiry repeated");
	smi_on_expiry_a: assert property (state_q == gapm_pkg::ST_NORMAL && expire_p |=> !mgmt_interrupt_n)
		else $error("no interrupt on expiry");
	flush_first_a: assert property ($fell(mgmt_active_n) |-> $past(cache_flush))
		else $error("active without flush");
	remap_tied_a: assert property (remap_en == !mgmt_active_n) else $error("remap not tied to active");
	normal_quiet_a: assert property (state_q == gapm_pkg::ST_NORMAL |-> cpu_clock_stop_n && !cpu_clock_slow
		&& !monitor_off) else $error("saving output in normal");
	stop_from_port_a: assert property (state_q == gapm_pkg::ST_GREEN |->
		cpu_clock_stop_n == !$past(pm_q[gapm_pkg::PM_STOP_IDX][0])) else $error("stop not from port");
	wake_exit_a: assert property (state_q == gapm_pkg::ST_GREEN && wake |=> state_q == gapm_pkg::ST_NORMAL
		##1 !low_power_mgmt_state) else $error("wake ignored");
	no_wake_hold_a: assert property (state_q == gapm_pkg::ST_GREEN && !wake |=> state_q == gapm_pkg::ST_GREEN)
		else $error("left low power without wake");
	kbd_act_a: assert property (acc.valid && acc.is_io && io_a == gapm_pkg::KBD_CMD
		&& cfg.act_en[gapm_pkg::SRC_KBD] |-> act) else $error("keyboard not activity");

	full_cycle_c: cover property (state_q == gapm_pkg::ST_GREEN ##1 state_q == gapm_pkg::ST_NORMAL);
	flush_c: cover property ($rose(cache_flush) ##[1:20] $fell(mgmt_active_n));
	stop_c: cover property ($fell(cpu_clock_stop_n));
endmodule : gapm_power_manager

//--- inc/gapm_pkg.sv
// shared constants and carriers for the activity-based power manager
package gapm_pkg;
	localparam int CLK_NS            = 10;
	localparam int TICK_NS           = 1000;
	localparam int TICK_CYC          = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int RELOAD_W          = 16;
	localparam logic [15:0] KBD_DATA = 16'h0060;
	localparam logic [15:0] KBD_CMD  = 16'h0064;
	localparam logic [23:0] VID_MEM_LO = 24'h0a0000;
	localparam logic [23:0] VID_MEM_HI = 24'h0bffff;
	localparam logic [15:0] VID_IO_LO  = 16'h03b0;
	localparam logic [15:0] VID_IO_HI  = 16'h03df;
	localparam logic [15:0] HDD0_LO    = 16'h01f0;
	localparam logic [15:0] HDD0_HI    = 16'h01f7;
	localparam logic [15:0] HDD0_ALT   = 16'h03f6;
	localparam logic [15:0] HDD1_LO    = 16'h0170;
	localparam logic [15:0] HDD1_HI    = 16'h0177;
	localparam logic [15:0] FDC_DATA   = 16'h03f5;
	localparam logic [23:0] VEC_HI     = 24'h0003ff;
	localparam logic [3:0]  REMAP_SEG  = 4'h3;
	localparam logic [7:0]  PM_FIRST   = 8'ha0;
	localparam logic [7:0]  PM_LAST    = 8'hae;
	localparam int PM_DEPTH            = 15;
	localparam logic [3:0]  PM_CLK_IDX  = 4'h0;
	localparam logic [3:0]  PM_STOP_IDX = 4'h2;
	localparam logic [3:0]  PM_MON_IDX  = 4'h4;
	// activity source bit positions
	localparam int SRC_IRQ = 0;
	localparam int SRC_DMA = 1;
	localparam int SRC_IOR = 2;
	localparam int SRC_KBD = 3;
	localparam int SRC_VID = 4;
	localparam int SRC_DSK = 5;
	localparam int SRC_EXT = 6;
	localparam int SRC_VEC = 7;
	localparam int SRC_N   = 8;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'b0001,
		ST_FLUSH  = 4'b0010,
		ST_ACTIVE = 4'b0100,
		ST_GREEN  = 4'b1000
	} gapm_state_e;

	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic [23:0] addr;
	} gapm_acc_s;

	typedef struct packed {
		logic [RELOAD_W-1:0] reload;
		logic [15:0]         io_lo;
		logic [15:0]         io_hi;
		logic [SRC_N-1:0]    act_en;
		logic [SRC_N-1:0]    wake_en;
		logic [7:0]          vec_mask0;
		logic [7:0]          vec_mask1;
		logic [1:0]          vec_mask_en;
	} gapm_cfg_s;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} gapm_pmw_s;
endpackage : gapm_pkg

//--- testbench/gapm_cpu_model.sv
// host cpu model: answers the management interrupt and runs a short handler
`timescale 1ns/100ps
module gapm_cpu_model (
	input  wire logic          clk,
	input  wire logic          mgmt_interrupt_n,
	input  wire logic          mgmt_active_n,
	input  wire logic [2:0]    pv,
	input  wire logic [3:0]    lag,
	output gapm_pkg::gapm_pmw_s pm_wr,
	output logic               flush_done,
	output logic               handler_exit
);
	initial begin
		pm_wr = '0;
		flush_done = 1'b0;
		handler_exit = 1'b0;
		forever begin
			@(negedge clk);
			if (!mgmt_interrupt_n) begin
				// lag varies so the flush answer comes both promptly and late
				repeat (lag) @(negedge clk);
				flush_done = 1'b1;
				@(negedge clk);
				flush_done = 1'b0;
				while (mgmt_active_n) @(negedge clk);
				for (int i = 0; i < 3; i++) begin
					pm_wr = '{wr: 1'b1, addr: 8'ha0 + 8'(2 * i), data: {7'h55, pv[i]}};
					@(negedge clk);
				end
				// one byte past the port, must be dropped
				pm_wr = '{wr: 1'b1, addr: 8'haf, data: 8'hff};
				@(negedge clk);
				pm_wr = '0;
				handler_exit = 1'b1;
				@(negedge clk);
				handler_exit = 1'b0;
			end
		end
	end
endmodule : gapm_cpu_model

//--- testbench/gapm_power_manager_tb.sv
// bench: activity sources, timer expiry, management handshake, port and wake
`timescale 1ns/100ps
module gapm_power_manager_tb;
	localparam int T = 2;
	localparam int R = 10;
	localparam logic [24:0] MISS [8] = '{25'h1000065, 25'h10003e0, 25'h10001f8, 25'h10003f4,
		25'h1000320, 25'h00c0000, 25'h000004c, 25'h00000df};
	typedef struct {int lo; int hi; logic [5:0] v;} gapm_note_s;
	logic                clk, arst_n, external_pm_event, flush_done, handler_exit, pi, pa, pl, rh;
	logic                mgmt_interrupt_n, mgmt_active_n, cache_flush, remap_en, remap_hit;
	logic                cpu_clock_stop_n, cpu_clock_slow, monitor_off, low_power_mgmt_state;
	gapm_pkg::gapm_cfg_s cfg;
	gapm_pkg::gapm_acc_s acc;
	gapm_pkg::gapm_pmw_s pm_wr;
	logic [15:0]         irq;
	logic [7:0]          dma_req, lfsr, r;
	logic [5:0]          v;
	logic [2:0]          pv, npv;
	logic [3:0]          lag;
	int                  mismatches, samples_checked, cyc, act_cyc, k;
	gapm_note_s          n;
	gapm_note_s          notes[$];

	gapm_power_manager #(.TICK_CYC(T)) gapm_power_manager_inst (.clk(clk), .arst_n(arst_n), .cfg(cfg), .acc(acc),
		.irq(irq), .dma_req(dma_req), .external_pm_event(external_pm_event), .flush_done(flush_done),
		.handler_exit(handler_exit), .pm_wr(pm_wr), .mgmt_interrupt_n(mgmt_interrupt_n),
		.mgmt_active_n(mgmt_active_n), .cache_flush(cache_flush), .remap_en(remap_en), .remap_hit(remap_hit),
		.cpu_clock_stop_n(cpu_clock_stop_n), .cpu_clock_slow(cpu_clock_slow), .monitor_off(monitor_off),
		.low_power_mgmt_state(low_power_mgmt_state));
	gapm_cpu_model gapm_cpu_model_inst (.clk(clk), .mgmt_interrupt_n(mgmt_interrupt_n),
		.mgmt_active_n(mgmt_active_n), .pv(npv), .lag(lag), .pm_wr(pm_wr), .flush_done(flush_done),
		.handler_exit(handler_exit));

	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nxt

	function automatic logic [5:0] ev(input logic [2:0] p, input logic ra, input logic fl);
		return {~p[1], p[0], p[2], ra, 1'b1, fl};
	endfunction : ev

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// one activity of source s, random within its range
	task automatic fire(input int s);
		gapm_pkg::gapm_acc_s a;
		lfsr = nxt(lfsr);
		r = lfsr;
		act_cyc = cyc;
		a = '{1'b0, 1'b1, 24'h0};
		case (s)
			0: irq[r[3:0]] = 1'b1;
			1: dma_req[r[2:0]] = 1'b1;
			2: a.addr = 24'h000300 + r[4:0];
			3: a.addr = r[0] ? 24'h64 : 24'h60;
			4: a = r[0] ? '{1'b0, 1'b1, 24'h0003b0 + 24'(r % 48)} : '{1'b0, 1'b0, r[1] ? 24'h0bffff : 24'h0a0000 + {r, r}};
			5: a.addr = r[1] ? (r[0] ? 24'h3f5 : 24'h170 + r[4:2]) : (r[0] ? 24'h3f6 : 24'h1f0 + r[4:2]);
			6: external_pm_event = 1'b1;
			default: a = '{1'b0, 1'b0, {14'h0, (r == 8'h13 || r == 8'h37) ? 8'h00 : r, r[1:0]}};
		endcase
		a.valid = (s > 1 && s != 6);
		// one assignment per edge so the design never sees a half-built access
		acc = a;
		@(negedge clk);
		irq = '0;
		dma_req = '0;
		external_pm_event = 1'b0;
		acc.valid = 1'b0;
		@(negedge clk);
	endtask : fire

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	// watcher: every result takes the oldest note
	initial begin
		{pi, pa, pl} = 3'h6;
		forever begin
			@(posedge clk);
			#1;
			v = {cpu_clock_stop_n, cpu_clock_slow, monitor_off, remap_en, low_power_mgmt_state, cache_flush};
			if ((pi && !mgmt_interrupt_n) || (pa !== mgmt_active_n && arst_n) || (pl && !low_power_mgmt_state)) begin
				n = '{0, -1, 6'h00};
				if (notes.size() != 0) begin
					n = notes.pop_front();
				end
				samples_checked++;
				if (v !== n.v || cyc - act_cyc < n.lo || cyc - act_cyc > n.hi) begin
					mismatches++;
					$display("ERROR t=%0t got=%h/%h exp=%h/%h", $time, v, cyc - act_cyc, n.v, n.hi);
				end
			end
			pi = mgmt_interrupt_n;
			pa = mgmt_active_n;
			pl = low_power_mgmt_state;
		end
	end

	initial begin
		#100us;
		mismatches++;
		stop_test();
	end

	initial begin
		{arst_n, irq, dma_req, external_pm_event, acc, pv} = '0;
		{mismatches, samples_checked} = '0;
		lfsr = 8'h2f;
		cfg = '{16'(R), 16'h0300, 16'h031f, 8'h0, 8'h0, 8'h13, 8'h37, 2'b11};
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		for (int s = 0; s < 8; s++) begin
			cfg.act_en = 8'h01 << s;
			cfg.wake_en = 8'h01 << s;
			npv = lfsr[2:0];
			lag = lfsr[6:3];
			repeat (4) fire(s);
			notes.push_back('{(R - 1) * T + 1, R * T + 4, ev(pv, 1'b0, 1'b1)});
			notes.push_back('{0, 100000, ev(pv, 1'b1, 1'b0)});
			notes.push_back('{0, 100000, ev(npv, 1'b0, 1'b0)});
			repeat (8) @(negedge clk);
			foreach (MISS[i]) begin
				acc = '{1'b1, MISS[i][24], MISS[i][23:0]};
				@(negedge clk);
			end
			rh = 1'b0;
			for (k = 0; k < 300 && !(low_power_mgmt_state && mgmt_active_n && notes.size() == 0); k++) begin
				// one memory access in the 3xxxx segment on the first cycle of the handler
				acc = '{!mgmt_active_n && !rh, 1'b0, {8'h03, r, lfsr}};
				rh = rh || acc.valid;
				@(negedge clk);
				if (acc.valid) begin
					samples_checked++;
					if (remap_hit !== 1'b1) begin
						mismatches++;
						$display("ERROR t=%0t got=%h exp=%h", $time, remap_hit, 1'b1);
					end
				end
			end
			if (k == 300) begin
				mismatches++;
				$display("ERROR t=%0t got=%h exp=%h", $time, k, 0);
			end
			pv = npv;
			fire((s + 1) % 8);
			repeat (4) @(negedge clk);
			notes.push_back('{1, 4, 6'h20});
			fire(s);
			for (k = 0; k < 20 && notes.size() != 0; k++) @(negedge clk);
			if (notes.size() != 0) begin
				mismatches++;
				$display("ERROR t=%0t got=%h exp=%h", $time, notes.size(), 0);
				notes.delete();
			end
			$display("test source %0d done", s);
		end
		stop_test();
	end
endmodule : gapm_power_manager_tb
